// ---- shared/fpd_pkg.sv ----
// Constants, register map and shared decode for the four-phase divider block
package fpd_pkg;

    localparam int FPD_DIV_W = 6;
    localparam int FPD_CNT_W = 4;
    localparam int FPD_LEN_W = 5;
    localparam int FPD_LSB_W = 2;

    // Counter end points with and without the increment line
    localparam logic [3:0] FPD_END_PLAIN = 4'h2;
    localparam logic [3:0] FPD_END_INC = 4'h1;

    // Divide number reset value (divide by 16)
    localparam logic [5:0] FPD_DIV_RST = 6'h10;

    // Register map, byte addresses
    localparam logic [7:0] FPD_ADDR_CTRL = 8'h00;
    localparam logic [7:0] FPD_ADDR_STATUS = 8'h04;
    localparam logic [7:0] FPD_ADDR_ACTIVE = 8'h08;
    localparam logic [7:0] FPD_ADDR_SEQCNT = 8'h0C;

    // Field positions
    localparam int FPD_CTRL_N_LSB = 0;
    localparam int FPD_CTRL_M_LSB = 8;

    localparam logic [1:0] FPD_RESP_OKAY = 2'h0;
    localparam logic [1:0] FPD_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        FPD_LSB_NONE,
        FPD_LSB_ONE,
        FPD_LSB_TWO,
        FPD_LSB_THREE
    } fpd_rem_t;

    // Sequence states (halving, quarter): 00, 11, 01, 10 for cycles one to four.
    // Extra counts: rem 1 -> cycle 3; rem 2 -> cycles 2,4; rem 3 -> cycles 2,3,4.
    function automatic logic fpd_inc_decode(
        input logic half,
        input logic quart,
        input logic [1:0] rem
    );
        logic inc;
        inc = 1'b0;
        case (fpd_rem_t'(rem))
            FPD_LSB_ONE: inc = ~half & quart;
            FPD_LSB_TWO: inc = half;
            FPD_LSB_THREE: inc = half | quart;
            default: inc = 1'b0;
        endcase
        return inc;
    endfunction : fpd_inc_decode

endpackage : fpd_pkg

// ---- hdl/fpd_divider.sv ----
// One four-phase programmable divider: down counter, end decode, sequence and output flops
`timescale 1ns/1ps
module fpd_divider
    import fpd_pkg::*;
#(
    parameter int DIV_W = FPD_DIV_W
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_adv,
    input wire logic [DIV_W-1:0] i_div,
    input wire logic i_pass_all,
    output logic o_out,
    output logic o_cc,
    output logic o_half,
    output logic o_quart,
    output logic o_seq_last
);

    if (DIV_W != FPD_DIV_W)
    begin : g_chk
        $error("fpd_divider needs a six-bit divide number");
    end

    logic [FPD_CNT_W-1:0] cnt_q;
    logic cc_q;
    logic out_q;
    logic half_q;
    logic quart_q;
    logic increment_line;
    logic eoc;

    assign increment_line = fpd_inc_decode(half_q, quart_q, i_div[1:0]);
    assign eoc = ~cc_q & (increment_line ? (cnt_q == FPD_END_INC)
                                         : (cnt_q == FPD_END_PLAIN));
    assign o_seq_last = i_adv & eoc & half_q & ~quart_q;

    // Down counter reloads while the complement of the count-control flop is low
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            cnt_q <= '0;
        else if (i_adv && cc_q)
            cnt_q <= i_div[DIV_W-1:2];
        else if (i_adv)
            cnt_q <= cnt_q - 4'h1;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            cc_q <= 1'b1;
        else if (i_adv)
            cc_q <= eoc;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            out_q <= 1'b0;
        else if (i_adv)
            out_q <= eoc & (i_pass_all | half_q);
    end

    // Modified ring: 00 -> 11 -> 01 -> 10 -> 00
    // Reset holds the cycle-four state so the first load after reset starts cycle one
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            half_q <= 1'b1;
            quart_q <= 1'b0;
        end
        else if (i_adv && cc_q)
        begin
            half_q <= ~half_q;
            quart_q <= ~(half_q ^ quart_q);
        end
    end

    assign o_out = out_q;
    assign o_cc = cc_q;
    assign o_half = half_q;
    assign o_quart = quart_q;

    // Checking helpers: cycle length and the load value of the current cycle
    logic [FPD_LEN_W-1:0] len_q;
    logic [FPD_CNT_W-1:0] hi_ld_q;
    logic started_q;
    logic inc_at_eoc_q;
    logic out_pass_q;

    // Halving control as seen by the output flop at its last update
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            len_q <= '0;
            hi_ld_q <= '0;
            started_q <= 1'b0;
            inc_at_eoc_q <= 1'b0;
            out_pass_q <= 1'b0;
        end
        else if (i_adv)
        begin
            out_pass_q <= i_pass_all;
            len_q <= cc_q ? 5'h1 : len_q + 5'h1;
            if (cc_q)
                hi_ld_q <= i_div[DIV_W-1:2];
            if (cc_q)
                started_q <= 1'b1;
            inc_at_eoc_q <= increment_line;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_load_high_bits: assert property (i_adv && cc_q |=> cnt_q == $past(i_div[DIV_W-1:2]))
        else $error("counter did not load the high divide bits");
    a_count_down: assert property (i_adv && !cc_q |=> cnt_q == $past(cnt_q) - 4'h1)
        else $error("counter did not step down by one");
    a_cycle_length: assert property (i_adv && cc_q && started_q && len_q > 5'h1 |->
        len_q == {1'b0, hi_ld_q} + {4'h0, inc_at_eoc_q})
        else $error("count cycle length is not load value plus increment");
    a_end_decode: assert property (i_adv && !cc_q && !increment_line && cnt_q == FPD_END_PLAIN
        |=> cc_q)
        else $error("end of count at 0010 missed");
    a_cc_inhibit: assert property (i_adv && cc_q |=> !cc_q)
        else $error("count-control flop held high for two clocks");
    a_seq_step: assert property (i_adv && cc_q |=> half_q != $past(half_q) &&
        quart_q == !($past(half_q) ^ $past(quart_q)))
        else $error("sequence flops did not step");
    a_no_inc_even: assert property (i_div[1:0] == 2'h0 |-> !increment_line)
        else $error("increment with remainder zero");
    a_out_mirror: assert property (out_pass_q |-> out_q == cc_q)
        else $error("output flop differs from count-control flop");
    a_out_halved: assert property (out_q |-> out_pass_q || $past(half_q))
        else $error("output passed while halving flop low");

    c_extra_count: cover property (i_adv && cc_q && inc_at_eoc_q);
    c_full_sequence: cover property (o_seq_last ##1 cc_q);

endmodule : fpd_divider

// ---- hdl/fpd_phase_det.sv ----
// Phase/frequency detector fed by the one-clock N divider pulse and the M divider pulse, which lasts one count event
`timescale 1ns/1ps
module fpd_phase_det
    import fpd_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_n_pulse,
    input wire logic i_m_pulse,
    output logic o_up,
    output logic o_dn
);

    logic up_q;
    logic dn_q;
    logic both;

    // Both set means the slower edge arrived: clear together, so width tracks phase lag
    assign both = up_q & dn_q;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            up_q <= 1'b0;
        else
            up_q <= (up_q | i_n_pulse) & ~both;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            dn_q <= 1'b0;
        else
            dn_q <= (dn_q | i_m_pulse) & ~both;
    end

    assign o_up = up_q;
    assign o_dn = dn_q;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_pfd_lead_n: assert property (i_n_pulse && !i_m_pulse && !up_q && !dn_q |=> up_q && !dn_q)
        else $error("N edge did not raise only the first output");
    a_pfd_clear: assert property (up_q && dn_q |=> !up_q && !dn_q)
        else $error("detector outputs not cleared together");

    c_locked: cover property (i_n_pulse && i_m_pulse ##1 up_q && dn_q ##1 !up_q && !dn_q);

endmodule : fpd_phase_det

// ---- hdl/fpd_top.sv ----
// Top of the four-phase divider pair: AXI4-Lite registers, N and M dividers, detector
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module fpd_top
    import fpd_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_m_tick,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    output logic [1:0] o_s_axi_bresp,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    input wire logic [ADDR_W-1:0] i_s_axi_araddr,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_n_div_out,
    output logic o_m_div_out,
    output logic o_pfd_up,
    output logic o_pfd_dn
);

    if (ADDR_W < 8 || ADDR_W > 32)
    begin : g_chk
        $error("fpd_top address width out of range");
    end

    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'h0)
            && (a[ADDR_W-1:2] <= (ADDR_W-2)'(FPD_ADDR_SEQCNT[7:2]));
    endfunction : addr_known

    // Configured and active divide numbers
    logic [FPD_DIV_W-1:0] cfg_n_q;
    logic [FPD_DIV_W-1:0] cfg_m_q;
    logic [FPD_DIV_W-1:0] act_n_q;
    logic [FPD_DIV_W-1:0] act_m_q;
    logic [15:0] seq_cnt_q;

    logic n_out;
    logic n_cc;
    logic n_half;
    logic n_quart;
    logic n_seq_last;
    logic m_out;
    logic m_cc;
    logic m_half;
    logic m_quart;
    logic m_seq_last;
    logic pass_all;
    logic up;
    logic dn;

    // Either top N bit high means N of 16 or more; it steers both dividers
    assign pass_all = act_n_q[FPD_DIV_W-1] | act_n_q[FPD_DIV_W-2];

    fpd_divider #(
        .DIV_W(FPD_DIV_W)
    ) u_n_div (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_adv(1'b1),
        .i_div(act_n_q),
        .i_pass_all(pass_all),
        .o_out(n_out),
        .o_cc(n_cc),
        .o_half(n_half),
        .o_quart(n_quart),
        .o_seq_last(n_seq_last)
    );

    fpd_divider #(
        .DIV_W(FPD_DIV_W)
    ) u_m_div (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_adv(i_m_tick),
        .i_div(act_m_q),
        .i_pass_all(pass_all),
        .o_out(m_out),
        .o_cc(m_cc),
        .o_half(m_half),
        .o_quart(m_quart),
        .o_seq_last(m_seq_last)
    );

    fpd_phase_det u_pfd (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_n_pulse(n_out),
        .i_m_pulse(m_out),
        .o_up(up),
        .o_dn(dn)
    );

    // Pin outputs re-registered so each comes straight from a flop here
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_n_div_out <= 1'b0;
            o_m_div_out <= 1'b0;
            o_pfd_up <= 1'b0;
            o_pfd_dn <= 1'b0;
        end
        else
        begin
            o_n_div_out <= n_out;
            o_m_div_out <= m_out;
            o_pfd_up <= up;
            o_pfd_dn <= dn;
        end
    end

    // New divide numbers take effect only at the last end of count of a sequence
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            act_n_q <= FPD_DIV_RST;
        else if (n_seq_last)
            act_n_q <= cfg_n_q;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            act_m_q <= FPD_DIV_RST;
        else if (m_seq_last)
            act_m_q <= cfg_m_q;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            seq_cnt_q <= '0;
        else if (n_seq_last)
            seq_cnt_q <= seq_cnt_q + 16'h1;
    end

    // Write channel: address and data taken together, answer follows
    logic wr_go;
    logic wr_hit;
    assign wr_go = i_s_axi_awvalid & i_s_axi_wvalid & ~o_s_axi_bvalid
                   & ~o_s_axi_awready;
    assign wr_hit = i_s_axi_awaddr == ADDR_W'(FPD_ADDR_CTRL);

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready <= 1'b0;
        end
        else
        begin
            o_s_axi_awready <= wr_go;
            o_s_axi_wready <= wr_go;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= FPD_RESP_OKAY;
        end
        else if (o_s_axi_awready)
        begin
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp <= (wr_hit || addr_known(i_s_axi_awaddr)) ? FPD_RESP_OKAY
                                                                     : FPD_RESP_SLVERR;
        end
        else if (i_s_axi_bready)
            o_s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            cfg_n_q <= FPD_DIV_RST;
            cfg_m_q <= FPD_DIV_RST;
        end
        else if (o_s_axi_awready && wr_hit)
        begin
            if (i_s_axi_wstrb[0])
                cfg_n_q <= i_s_axi_wdata[FPD_CTRL_N_LSB +: FPD_DIV_W];
            if (i_s_axi_wstrb[1])
                cfg_m_q <= i_s_axi_wdata[FPD_CTRL_M_LSB +: FPD_DIV_W];
        end
    end

    // Read channel
    logic rd_go;
    logic [31:0] rd_data;
    logic [1:0] rd_resp;
    assign rd_go = i_s_axi_arvalid & ~o_s_axi_rvalid & ~o_s_axi_arready;

    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_resp = FPD_RESP_OKAY;
        case (i_s_axi_araddr)
            ADDR_W'(FPD_ADDR_CTRL):
            begin
                rd_data[FPD_CTRL_N_LSB +: FPD_DIV_W] = cfg_n_q;
                rd_data[FPD_CTRL_M_LSB +: FPD_DIV_W] = cfg_m_q;
            end
            ADDR_W'(FPD_ADDR_STATUS):
                rd_data[9:0] = {m_half, m_quart, m_cc, n_half, n_quart, n_cc,
                                dn, up, m_out, n_out};
            ADDR_W'(FPD_ADDR_ACTIVE):
            begin
                rd_data[FPD_CTRL_N_LSB +: FPD_DIV_W] = act_n_q;
                rd_data[FPD_CTRL_M_LSB +: FPD_DIV_W] = act_m_q;
            end
            ADDR_W'(FPD_ADDR_SEQCNT):
                rd_data[15:0] = seq_cnt_q;
            default:
                rd_resp = FPD_RESP_SLVERR;
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            o_s_axi_arready <= 1'b0;
        else
            o_s_axi_arready <= rd_go;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= FPD_RESP_OKAY;
        end
        else if (o_s_axi_arready)
        begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata <= rd_data;
            o_s_axi_rresp <= rd_resp;
        end
        else if (i_s_axi_rready)
            o_s_axi_rvalid <= 1'b0;
    end

    // Checking helper: N count-control pulses within the current sequence
    logic [2:0] n_cc_cnt_q;
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            n_cc_cnt_q <= '0;
        else if (n_seq_last)
            n_cc_cnt_q <= '0;
        else if (n_cc)
            n_cc_cnt_q <= n_cc_cnt_q + 3'h1;
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_four_cycles: assert property (n_seq_last |-> n_cc_cnt_q == 3'h4 || $past(i_rst, 4))
        else $error("sequence did not hold four count cycles");
    a_apply_at_seq: assert property (act_n_q != $past(act_n_q) |-> $past(n_seq_last))
        else $error("divide number changed inside a sequence");
    a_m_halving: assert property (m_out && !pass_all && !$past(pass_all)
        && !$past(pass_all, 2) |-> $past(m_half))
        else $error("M output not halved for small N");
    a_axi_bhold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid
        && $stable(o_s_axi_bresp))
        else $error("write answer dropped before taken");

    c_write: cover property (o_s_axi_awready ##1 o_s_axi_bvalid);
    c_small_n: cover property (!pass_all && n_out);

endmodule : fpd_top

// ---- dv/fpd_mtick_src.sv ----
// Count-event source for the M divider, standing in for the IF clock
`timescale 1ns/1ps
module fpd_mtick_src
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_slow,
    output logic o_tick
);
    // Slow mode gives one count event every second clock
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_tick <= 1'b1;
        end
        else
        begin
            o_tick <= i_slow ? ~o_tick : 1'b1;
        end
    end
endmodule : fpd_mtick_src

// ---- dv/test_fpd_top.sv ----
// Self-checking bench for the four-phase divider pair
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_fpd_top;
    import fpd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic slow = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, n_out, m_out, up, dn, m_tick;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, data;
    int num_errors = 0, n_tests = 0, cyc = 0, up_cnt = 0, dn_cnt = 0, n, q;
    bit cnt_en = 1'b0;
    int tbl[8] = '{16, 19, 30, 32, 17, 11, 12, 15};

    always #20 clk = ~clk;

    fpd_mtick_src src_u (.i_clk_sys(clk), .i_rst(rst), .i_slow(slow), .o_tick(m_tick));

    fpd_top dut_u (
        .i_clk_sys(clk), .i_rst(rst), .i_m_tick(m_tick),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
        .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_n_div_out(n_out),
        .o_m_div_out(m_out), .o_pfd_up(up), .o_pfd_dn(dn)
    );

    task automatic results();
        $display("tests=%0d errors=%0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results

    // Cycle count, detector level counts and hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cnt_en)
        begin
            up_cnt += int'(up === 1'b1);
            dn_cnt += int'(dn === 1'b1);
        end
        if (cyc > 40000)
        begin
            num_errors++;
            results();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        resp = rresp;
        data = rdata;
        rready <= 1'b0;
    endtask : rd

    // Program N and M, then wait until both are active
    task automatic set_nm(input int nn, input int mm);
        int k;
        k = 0;
        wr(FPD_ADDR_CTRL, 32'(mm << 8 | nn), 4'h3);
        do
        begin
            rd(FPD_ADDR_ACTIVE);
            k++;
        end
        while (data !== 32'(mm << 8 | nn) && k < 40);
        `CHK(data, 32'(mm << 8 | nn))
    endtask : set_nm

    // Waits for a rising output so a pulse standing two clocks counts once
    task automatic nxt(input bit m, output int t);
        int k;
        logic prev, cur;
        k = 0;
        cur = m ? m_out : n_out;
        do
        begin
            prev = cur;
            @(posedge clk);
            #1;
            cur = m ? m_out : n_out;
            k++;
        end
        while (!(cur === 1'b1 && prev !== 1'b1) && k < 500);
        t = cyc;
    endtask : nxt

    // Pulse spacing: each gap within lo..hi, np gaps adding up to tot
    task automatic measure(input bit m, input int np, input int lo, input int hi, input int tot);
        int t0, t1, sum, bad;
        sum = 0;
        bad = 0;
        nxt(m, t0);
        repeat (np)
        begin
            nxt(m, t1);
            sum += t1 - t0;
            if (t1 - t0 < lo || t1 - t0 > hi) bad++;
            t0 = t1;
        end
        `CHK(sum, tot)
        `CHK(bad, 0)
    endtask : measure

    task automatic det(input int cycles);
        up_cnt = 0;
        dn_cnt = 0;
        cnt_en = 1'b1;
        repeat (cycles) @(posedge clk);
        cnt_en = 1'b0;
    endtask : det

    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        det(400);
        `CHK(up_cnt, dn_cnt)
        `CHK(up_cnt > 0, 1'b1)
        $display("test locked done");
        rd(FPD_ADDR_ACTIVE);
        `CHK(data, 32'h0000_1010)
        rd(8'h10);
        `CHK(resp, FPD_RESP_SLVERR)
        `CHK(data, 32'h0000_0000)
        wr(8'h10, 32'h0000_0b0b, 4'hf);
        `CHK(resp, FPD_RESP_SLVERR)
        wr(FPD_ADDR_ACTIVE, 32'h0000_0b0b, 4'hf);
        `CHK(resp, FPD_RESP_OKAY)
        rd(FPD_ADDR_ACTIVE);
        `CHK(data, 32'h0000_1010)
        // Two samples 160 clocks apart at N of 16 span exactly ten sequences
        rd(FPD_ADDR_SEQCNT);
        q = data;
        repeat (156) @(posedge clk);
        rd(FPD_ADDR_SEQCNT);
        `CHK(data, q + 32'h0000_000a)
        $display("test registers done");
        foreach (tbl[i])
        begin
            n = tbl[i];
            q = n / 4;
            set_nm(n, n);
            for (int s = 0; s < 2; s++)
            begin
                if (n >= 16)
                    measure(s, 4, q, q + 1, n);
                else
                    measure(s, 2, 2 * q, 2 * q + 2, n);
            end
        end
        $display("test divide table done");
        set_nm(12, 20);
        measure(1, 2, 10, 10, 20);
        measure(0, 2, 6, 6, 12);
        $display("test m halving done");
        set_nm(32, 12);
        det(600);
        `CHK(dn_cnt > up_cnt, 1'b1)
        set_nm(16, 16);
        slow <= 1'b1;
        measure(1, 4, 8, 8, 32);
        det(600);
        `CHK(up_cnt > dn_cnt, 1'b1)
        $display("test detector done");
        results();
    end
endmodule : test_fpd_top
